// ### verilog/slcr_top.sv
// link configuration registers and exchange muxes
// Function
// RL1: lane exchange crosses outputs to lanes.
// RL2: converter exchange crosses serial inputs.
// RL3: three-bit pad swing select.
// RL4: seed low seven bits, reset zeros.
// RL5: seed high byte, reset ones.
// RL6: pattern 00/01 7-stage, 10 23-stage, 11 31-stage.
// RL7: read-only link identifier byte.
// RL8: four-bit bank identifier, upper nibble zero.
// RL9: bit 7 scramble enable, bit 0 lanes minus one.
// RL10: octets per frame minus one, three bits.
// RL11: frames per multiframe minus one, five bits.
// RL12: converters minus one in bit 0, rest zero.
// RL13: bit 6 control bits, bits 3..0 resolution.
// RL14: bits per sample minus one, five bits.
// RL15: samples per frame bit, resets to one.
// RL16: bit 7 high density, bits 1..0 control words.
// RL17: first lane identifier, reset 11011.
// RL18: second lane identifier, reset 11100.
// RL19: lane checksums, parameter sum modulo 256.
// RL20: software quick configuration beats straps.
// RL21: unused bits read constant, ignore writes.
`timescale 1ns/10ps
`default_nettype none
module slcr_top
   import slcr_pkg::*;
#(
   parameter int SAMPLE_W = 12,
   parameter int LANE_W = 10,
   // arbitrary neutral identity values
   parameter logic [7:0] LINK_ID_VALUE = 8'h5a,
   parameter logic [3:0] BANK_ID_RESET = 4'h3
) (
   input wire logic clock_i,
   input wire logic reset_n_i,
   // register port
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic wr_en_i,
   input wire logic [DATA_W-1:0] wr_data_i,
   input wire logic rd_en_i,
   output logic [DATA_W-1:0] rd_data_o,
   output logic rd_valid_o,
   // strap pads
   input wire logic [3:0] cfg_strap_i,
   // data paths
   input wire logic [SAMPLE_W-1:0] conv0_sample_i,
   input wire logic [SAMPLE_W-1:0] conv1_sample_i,
   output logic [SAMPLE_W-1:0] ser_in0_o,
   output logic [SAMPLE_W-1:0] ser_in1_o,
   input wire logic [LANE_W-1:0] ser_out0_i,
   input wire logic [LANE_W-1:0] ser_out1_i,
   output logic [LANE_W-1:0] lane0_data_o,
   output logic [LANE_W-1:0] lane1_data_o,
   // serial unit configuration
   output logic [2:0] swing_select_o,
   output logic [14:0] scrambler_seed_o,
   output logic [1:0] pattern_sequence_select_o,
   output logic [7:0] link_identifier_o,
   output logic [3:0] bank_identifier_o,
   output logic scramble_enable_o,
   output logic lanes_o,
   output logic [2:0] octets_o,
   output logic [4:0] frames_o,
   output logic converters_o,
   output logic control_bits_o,
   output logic [3:0] resolution_o,
   output logic [4:0] total_bits_per_sample_o,
   output logic samples_o,
   output logic high_density_flag_o,
   output logic [1:0] control_words_per_frame_o,
   output logic [4:0] lane0_identifier_o,
   output logic [4:0] lane1_identifier_o,
   output logic [7:0] lane0_checksum_o,
   output logic [7:0] lane1_checksum_o
);
   // write decode
   wire wr_quick = wr_en_i && addr_i == OFF_QUICK_CFG;
   wire wr_swap = wr_en_i && addr_i == OFF_SWAP;
   wire wr_swing = wr_en_i && addr_i == OFF_SWING;
   wire wr_seed_lo = wr_en_i && addr_i == OFF_SEED_LO;
   wire wr_seed_hi = wr_en_i && addr_i == OFF_SEED_HI;
   wire wr_pattern = wr_en_i && addr_i == OFF_PATTERN;
   wire wr_bank = wr_en_i && addr_i == OFF_BANK_ID;
   wire wr_scram = wr_en_i && addr_i == OFF_SCRAM;
   wire wr_octets = wr_en_i && addr_i == OFF_OCTETS;
   wire wr_frames = wr_en_i && addr_i == OFF_FRAMES;
   wire wr_conv = wr_en_i && addr_i == OFF_CONV;
   wire wr_cs_n = wr_en_i && addr_i == OFF_CS_N;
   wire wr_bps = wr_en_i && addr_i == OFF_BPS;
   wire wr_samples = wr_en_i && addr_i == OFF_SAMPLES;
   wire wr_dense_cw = wr_en_i && addr_i == OFF_DENSE_CW;
   wire wr_lane0 = wr_en_i && addr_i == OFF_LANE0_ID;
   wire wr_lane1 = wr_en_i && addr_i == OFF_LANE1_ID;

   logic [3:0] quick_cfg_reg;
   logic swap_lane_reg;
   logic swap_conv_reg;
   logic [6:0] seed_lo_reg;
   logic [7:0] seed_hi_reg;
   logic [1:0] pattern_reg;
   logic [3:0] bank_reg;
   logic scram_reg;
   logic lanes_reg;
   logic [2:0] octets_reg;
   logic [4:0] frames_reg;
   logic conv_reg;
   logic cs_reg;
   logic [3:0] res_reg;
   logic [4:0] bps_reg;
   logic samples_reg;
   logic dense_reg;
   logic [1:0] cw_reg;
   logic [4:0] lane0_id_reg;
   logic [4:0] lane1_id_reg;

   // strap synchroniser and settle counter
   logic [3:0] strap_meta_reg;
   logic [3:0] strap_sync_reg;
   logic [1:0] settle_reg;
   logic strap_done_reg;

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         strap_meta_reg <= 4'h0;
         strap_sync_reg <= 4'h0;
      end else begin
         strap_meta_reg <= cfg_strap_i;
         strap_sync_reg <= strap_meta_reg;
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         settle_reg <= 2'h0;
      end else if (settle_reg != STRAP_SETTLE) begin
         settle_reg <= settle_reg + 2'h1;
      end
   end

   // RL20 a prior write cancels the strap load
   wire strap_load = (settle_reg == STRAP_SETTLE) && !strap_done_reg && !wr_quick;

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         strap_done_reg <= 1'b0;
      end else if (strap_load || wr_quick) begin
         strap_done_reg <= 1'b1;
      end
   end

   // RL20 quick configuration source
   wire [3:0] quick_code = wr_quick ? wr_data_i[3:0] : strap_sync_reg;
   wire apply_preset = wr_quick || strap_load;

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         quick_cfg_reg <= RST_QUICK_CFG;
      end else if (apply_preset) begin
         quick_cfg_reg <= quick_code;
      end
   end

   // codes without a preset leave the exchange and link fields unchanged
   logic preset_ok;
   logic [2:0] preset_f;
   logic [4:0] preset_k;
   logic preset_m;
   logic preset_l;
   logic preset_dense;
   logic preset_swap_conv;
   logic preset_swap_lane;

   always_comb begin
      preset_ok = 1'b1;
      preset_f = 3'h1;
      preset_k = 5'h08;
      preset_m = 1'b1;
      preset_l = 1'b1;
      preset_dense = 1'b0;
      preset_swap_conv = 1'b0;
      preset_swap_lane = 1'b0;
      unique case (quick_code)
         4'h1: begin
            preset_f = 3'h3;
            preset_k = 5'h04;
            preset_l = 1'b0;
         end
         4'h3, 4'h4: begin
            preset_f = 3'h0;
            preset_k = 5'h10;
            preset_m = 1'b0;
            preset_dense = 1'b1;
            preset_swap_conv = (quick_code == 4'h4);
         end
         4'h5, 4'h6, 4'h7, 4'h8: begin
            preset_m = 1'b0;
            preset_l = 1'b0;
            preset_swap_lane = (quick_code == 4'h6);
            preset_swap_conv = (quick_code == 4'h7) || (quick_code == 4'h8);
         end
         4'h0, 4'he, 4'hf: preset_ok = 1'b1;
         default: begin
            preset_ok = 1'b0;
         end
      endcase
   end

   wire do_preset = apply_preset && preset_ok;

   // RL1 RL2 exchange; a field write beats a preset
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         swap_lane_reg <= 1'b0;
         swap_conv_reg <= 1'b0;
      end else if (wr_swap) begin
         swap_lane_reg <= wr_data_i[POS_SWAP_LANE];
         swap_conv_reg <= wr_data_i[POS_SWAP_CONV];
      end else if (do_preset) begin
         swap_lane_reg <= preset_swap_lane;
         swap_conv_reg <= preset_swap_conv;
      end
   end

   // RL3 RL4 RL5 RL6 serial unit controls
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         swing_select_o <= RST_SWING;
         seed_lo_reg <= RST_SEED_LO;
         seed_hi_reg <= RST_SEED_HI;
         pattern_reg <= RST_PATTERN;
      end else begin
         if (wr_swing) swing_select_o <= wr_data_i[2:0];
         if (wr_seed_lo) seed_lo_reg <= wr_data_i[6:0];
         if (wr_seed_hi) seed_hi_reg <= wr_data_i;
         if (wr_pattern) pattern_reg <= wr_data_i[1:0];
      end
   end

   // RL8 RL13 RL14 RL15 RL16 link parameters
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bank_reg <= BANK_ID_RESET;
         cs_reg <= 1'b0;
         res_reg <= RST_RES;
         bps_reg <= RST_BPS;
         samples_reg <= RST_SAMPLES;
         cw_reg <= RST_CW;
      end else begin
         if (wr_bank) bank_reg <= wr_data_i[3:0];
         if (wr_cs_n) cs_reg <= wr_data_i[POS_CS];
         if (wr_cs_n) res_reg <= wr_data_i[3:0];
         if (wr_bps) bps_reg <= wr_data_i[4:0];
         if (wr_samples) samples_reg <= wr_data_i[0];
         if (wr_dense_cw) cw_reg <= wr_data_i[1:0];
      end
   end

   // RL9 RL10 RL11 RL12 RL16 fields; all but scram_reg take presets
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         scram_reg <= 1'b0;
         lanes_reg <= RST_LANES;
         octets_reg <= RST_OCTETS;
         frames_reg <= RST_FRAMES;
         conv_reg <= RST_CONV;
         dense_reg <= 1'b0;
      end else begin
         if (wr_scram) scram_reg <= wr_data_i[POS_SCRAM];
         if (wr_scram) lanes_reg <= wr_data_i[POS_LANES];
         else if (do_preset) lanes_reg <= preset_l;
         if (wr_octets) octets_reg <= wr_data_i[2:0];
         else if (do_preset) octets_reg <= preset_f;
         if (wr_frames) frames_reg <= wr_data_i[4:0];
         else if (do_preset) frames_reg <= preset_k;
         if (wr_conv) conv_reg <= wr_data_i[0];
         else if (do_preset) conv_reg <= preset_m;
         if (wr_dense_cw) dense_reg <= wr_data_i[POS_DENSE];
         else if (do_preset) dense_reg <= preset_dense;
      end
   end

   // RL17 RL18 lane identifiers
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         lane0_id_reg <= RST_LANE0_ID;
         lane1_id_reg <= RST_LANE1_ID;
      end else begin
         if (wr_lane0) lane0_id_reg <= wr_data_i[4:0];
         if (wr_lane1) lane1_id_reg <= wr_data_i[4:0];
      end
   end

   // RL19 per-lane checksums
   wire [7:0] chk0;
   wire [7:0] chk1;

   slcr_checksum u_chk0 (
      .link_identifier_i(LINK_ID_VALUE),
      .bank_identifier_i(bank_reg),
      .lane_identifier_i(lane0_id_reg),
      .scramble_enable_i(scram_reg),
      .lanes_i(lanes_reg),
      .octets_i(octets_reg),
      .frames_i(frames_reg),
      .converters_i(conv_reg),
      .control_bits_i(cs_reg),
      .resolution_i(res_reg),
      .total_bits_per_sample_i(bps_reg),
      .samples_i(samples_reg),
      .high_density_flag_i(dense_reg),
      .control_words_per_frame_i(cw_reg),
      .sum_o(chk0)
   );

   slcr_checksum u_chk1 (
      .link_identifier_i(LINK_ID_VALUE),
      .bank_identifier_i(bank_reg),
      .lane_identifier_i(lane1_id_reg),
      .scramble_enable_i(scram_reg),
      .lanes_i(lanes_reg),
      .octets_i(octets_reg),
      .frames_i(frames_reg),
      .converters_i(conv_reg),
      .control_bits_i(cs_reg),
      .resolution_i(res_reg),
      .total_bits_per_sample_i(bps_reg),
      .samples_i(samples_reg),
      .high_density_flag_i(dense_reg),
      .control_words_per_frame_i(cw_reg),
      .sum_o(chk1)
   );

   // RL2 converter exchange
   slcr_swap_mux #(
      .WIDTH(SAMPLE_W)
   ) u_conv_mux (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .swap_i(swap_conv_reg),
      .in0_i(conv0_sample_i),
      .in1_i(conv1_sample_i),
      .out0_o(ser_in0_o),
      .out1_o(ser_in1_o)
   );

   // RL1 lane exchange
   slcr_swap_mux #(
      .WIDTH(LANE_W)
   ) u_lane_mux (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .swap_i(swap_lane_reg),
      .in0_i(ser_out0_i),
      .in1_i(ser_out1_i),
      .out0_o(lane0_data_o),
      .out1_o(lane1_data_o)
   );

   // RL21 read mux, reserved bits zero
   logic [7:0] rd_mux;

   always_comb begin
      unique case (addr_i)
         OFF_QUICK_CFG: rd_mux = {4'h0, quick_cfg_reg};
         OFF_SWAP: rd_mux = {6'h00, swap_lane_reg, swap_conv_reg};
         OFF_SWING: rd_mux = {5'h00, swing_select_o};
         OFF_SEED_LO: rd_mux = {1'b0, seed_lo_reg};
         OFF_SEED_HI: rd_mux = seed_hi_reg;
         OFF_PATTERN: rd_mux = {6'h00, pattern_reg};
         // RL7 fixed identity, writes ignored
         OFF_LINK_ID: rd_mux = LINK_ID_VALUE;
         OFF_BANK_ID: rd_mux = {4'h0, bank_reg};
         OFF_SCRAM: rd_mux = {scram_reg, 6'h00, lanes_reg};
         OFF_OCTETS: rd_mux = {5'h00, octets_reg};
         OFF_FRAMES: rd_mux = {3'h0, frames_reg};
         OFF_CONV: rd_mux = {7'h00, conv_reg};
         OFF_CS_N: rd_mux = {1'b0, cs_reg, 2'h0, res_reg};
         OFF_BPS: rd_mux = {3'h0, bps_reg};
         OFF_SAMPLES: rd_mux = {7'h00, samples_reg};
         OFF_DENSE_CW: rd_mux = {dense_reg, 5'h00, cw_reg};
         OFF_LANE0_ID: rd_mux = {3'h0, lane0_id_reg};
         OFF_LANE1_ID: rd_mux = {3'h0, lane1_id_reg};
         OFF_LANE0_CHK: rd_mux = chk0;
         OFF_LANE1_CHK: rd_mux = chk1;
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rd_data_o <= 8'h00;
         rd_valid_o <= 1'b0;
      end else begin
         rd_valid_o <= rd_en_i;
         if (rd_en_i) rd_data_o <= rd_mux;
      end
   end

   // registered copies
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         scrambler_seed_o <= {RST_SEED_HI, RST_SEED_LO};
         pattern_sequence_select_o <= RST_PATTERN;
         link_identifier_o <= 8'h00;
         bank_identifier_o <= 4'h0;
         scramble_enable_o <= 1'b0;
         lanes_o <= RST_LANES;
         octets_o <= RST_OCTETS;
         frames_o <= RST_FRAMES;
         converters_o <= RST_CONV;
         control_bits_o <= 1'b0;
         resolution_o <= RST_RES;
         total_bits_per_sample_o <= RST_BPS;
         samples_o <= RST_SAMPLES;
         high_density_flag_o <= 1'b0;
         control_words_per_frame_o <= RST_CW;
         lane0_identifier_o <= RST_LANE0_ID;
         lane1_identifier_o <= RST_LANE1_ID;
         lane0_checksum_o <= 8'h00;
         lane1_checksum_o <= 8'h00;
      end else begin
         scrambler_seed_o <= {seed_hi_reg, seed_lo_reg};
         pattern_sequence_select_o <= pattern_reg;
         link_identifier_o <= LINK_ID_VALUE;
         bank_identifier_o <= bank_reg;
         scramble_enable_o <= scram_reg;
         lanes_o <= lanes_reg;
         octets_o <= octets_reg;
         frames_o <= frames_reg;
         converters_o <= conv_reg;
         control_bits_o <= cs_reg;
         resolution_o <= res_reg;
         total_bits_per_sample_o <= bps_reg;
         samples_o <= samples_reg;
         high_density_flag_o <= dense_reg;
         control_words_per_frame_o <= cw_reg;
         lane0_identifier_o <= lane0_id_reg;
         lane1_identifier_o <= lane1_id_reg;
         lane0_checksum_o <= chk0;
         lane1_checksum_o <= chk1;
      end
   end
endmodule // slcr_top
`default_nettype wire

// ### common/slcr_pkg.sv
// constants for the serial link configuration register bank
package slcr_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   // register offsets
   localparam logic [11:0] OFF_QUICK_CFG = 12'h804;
   localparam logic [11:0] OFF_SWAP = 12'h806;
   localparam logic [11:0] OFF_SWING = 12'h808;
   localparam logic [11:0] OFF_SEED_LO = 12'h809;
   localparam logic [11:0] OFF_SEED_HI = 12'h80a;
   localparam logic [11:0] OFF_PATTERN = 12'h80b;
   localparam logic [11:0] OFF_LINK_ID = 12'h820;
   localparam logic [11:0] OFF_BANK_ID = 12'h821;
   localparam logic [11:0] OFF_SCRAM = 12'h822;
   localparam logic [11:0] OFF_OCTETS = 12'h823;
   localparam logic [11:0] OFF_FRAMES = 12'h824;
   localparam logic [11:0] OFF_CONV = 12'h825;
   localparam logic [11:0] OFF_CS_N = 12'h826;
   localparam logic [11:0] OFF_BPS = 12'h827;
   localparam logic [11:0] OFF_SAMPLES = 12'h828;
   localparam logic [11:0] OFF_DENSE_CW = 12'h829;
   localparam logic [11:0] OFF_LANE0_ID = 12'h82c;
   localparam logic [11:0] OFF_LANE1_ID = 12'h82d;
   localparam logic [11:0] OFF_LANE1_CHK = 12'h84c;
   localparam logic [11:0] OFF_LANE0_CHK = 12'h84d;
   // field positions
   localparam int POS_SWAP_LANE = 1;
   localparam int POS_SWAP_CONV = 0;
   localparam int POS_SCRAM = 7;
   localparam int POS_LANES = 0;
   localparam int POS_CS = 6;
   localparam int POS_DENSE = 7;
   // reset values
   localparam logic [3:0] RST_QUICK_CFG = 4'h0;
   localparam logic [2:0] RST_SWING = 3'h0;
   localparam logic [6:0] RST_SEED_LO = 7'h00;
   localparam logic [7:0] RST_SEED_HI = 8'hff;
   localparam logic [1:0] RST_PATTERN = 2'h0;
   localparam logic [2:0] RST_OCTETS = 3'h1;
   localparam logic [4:0] RST_FRAMES = 5'h08;
   localparam logic RST_CONV = 1'b1;
   localparam logic RST_LANES = 1'b1;
   localparam logic [3:0] RST_RES = 4'hb;
   localparam logic [4:0] RST_BPS = 5'h0f;
   localparam logic RST_SAMPLES = 1'b1;
   localparam logic [1:0] RST_CW = 2'h0;
   localparam logic [4:0] RST_LANE0_ID = 5'h1b;
   localparam logic [4:0] RST_LANE1_ID = 5'h1c;
   // settle cycles before straps are trusted
   localparam logic [1:0] STRAP_SETTLE = 2'h3;
   // pattern generator codes
   typedef enum logic [1:0] {
      SLCR_PRBS7_A = 2'b00,
      SLCR_PRBS7_B = 2'b01,
      SLCR_PRBS23 = 2'b10,
      SLCR_PRBS31 = 2'b11
   } slcr_pattern_t;
endpackage

// ### verilog/slcr_swap_mux.sv
// registered two-way exchange multiplexer
`timescale 1ns/10ps
`default_nettype none
module slcr_swap_mux #(
   parameter int WIDTH = 12
) (
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic swap_i,
   input wire logic [WIDTH-1:0] in0_i,
   input wire logic [WIDTH-1:0] in1_i,
   output logic [WIDTH-1:0] out0_o,
   output logic [WIDTH-1:0] out1_o
);
   wire [WIDTH-1:0] sel0 = swap_i ? in1_i : in0_i;
   wire [WIDTH-1:0] sel1 = swap_i ? in0_i : in1_i;

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         out0_o <= '0;
         out1_o <= '0;
      end else begin
         out0_o <= sel0;
         out1_o <= sel1;
      end
   end
endmodule // slcr_swap_mux
`default_nettype wire

// ### verilog/slcr_checksum.sv
// per-lane link configuration checksum, sum modulo 256
`timescale 1ns/10ps
`default_nettype none
module slcr_checksum (
   input wire logic [7:0] link_identifier_i,
   input wire logic [3:0] bank_identifier_i,
   input wire logic [4:0] lane_identifier_i,
   input wire logic scramble_enable_i,
   input wire logic lanes_i,
   input wire logic [2:0] octets_i,
   input wire logic [4:0] frames_i,
   input wire logic converters_i,
   input wire logic control_bits_i,
   input wire logic [3:0] resolution_i,
   input wire logic [4:0] total_bits_per_sample_i,
   input wire logic samples_i,
   input wire logic high_density_flag_i,
   input wire logic [1:0] control_words_per_frame_i,
   output logic [7:0] sum_o
);
   // carry dropped: modulo 256
   assign sum_o = link_identifier_i + {4'h0, bank_identifier_i}
      + {3'h0, lane_identifier_i} + {7'h00, scramble_enable_i}
      + {7'h00, lanes_i} + {5'h00, octets_i} + {3'h0, frames_i}
      + {7'h00, converters_i} + {7'h00, control_bits_i}
      + {4'h0, resolution_i} + {3'h0, total_bits_per_sample_i}
      + {7'h00, samples_i} + {7'h00, high_density_flag_i}
      + {6'h00, control_words_per_frame_i};
endmodule // slcr_checksum
`default_nettype wire

// ### tb/slcr_ser_model.sv
// serial unit model, fresh word per lane each cycle
`timescale 1ns/10ps
`default_nettype none
module slcr_ser_model #(
   parameter int LANE_W = 10
) (
   input wire logic clock_i,
   input wire logic reset_n_i,
   output logic [LANE_W-1:0] ser_out0_o,
   output logic [LANE_W-1:0] ser_out1_o
);
   logic [LANE_W-1:0] word_reg;
   // distinct words expose stale or crossed lanes
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) word_reg <= '0;
      else word_reg <= word_reg + LANE_W'(37);
   end
   assign ser_out0_o = word_reg;
   assign ser_out1_o = ~word_reg;
endmodule // slcr_ser_model
`default_nettype wire

// ### tb/slcr_top_properties.sv
// checker for the configuration registers
`timescale 1ns/10ps
`default_nettype none
module slcr_top_checker
   import slcr_pkg::*;
#(
   parameter int SAMPLE_W = 12,
   parameter int LANE_W = 10
) (
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic wr_en_i,
   input wire logic [DATA_W-1:0] wr_data_i,
   input wire logic rd_en_i,
   input wire logic [DATA_W-1:0] rd_data_o,
   input wire logic rd_valid_o,
   input wire logic [SAMPLE_W-1:0] conv0_sample_i,
   input wire logic [SAMPLE_W-1:0] conv1_sample_i,
   input wire logic [SAMPLE_W-1:0] ser_in0_o,
   input wire logic [LANE_W-1:0] ser_out0_i,
   input wire logic [LANE_W-1:0] ser_out1_i,
   input wire logic [LANE_W-1:0] lane0_data_o,
   input wire logic [14:0] scrambler_seed_o,
   input wire logic [1:0] pattern_sequence_select_o,
   input wire logic [7:0] link_identifier_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);
   wire sw_wr = wr_en_i && addr_i == OFF_SWAP;
   wire [1:0] wr_pat = wr_data_i[1:0];
   property p_lx; sw_wr && wr_data_i[1] |-> ##2 lane0_data_o == $past(ser_out1_i); endproperty
   property p_ls; sw_wr && !wr_data_i[1] |-> ##2 lane0_data_o == $past(ser_out0_i); endproperty
   property p_cx; sw_wr && wr_data_i[0] |-> ##2 ser_in0_o == $past(conv1_sample_i); endproperty
   property p_cs; sw_wr && !wr_data_i[0] |-> ##2 ser_in0_o == $past(conv0_sample_i); endproperty
   property p_rsv;
      rd_en_i && addr_i == OFF_SWAP |=> rd_valid_o && rd_data_o[7:2] == 6'h00;
   endproperty
   property p_lnk; rd_en_i && addr_i == OFF_LINK_ID |=> rd_data_o == link_identifier_o; endproperty
   property p_shi;
      wr_en_i && addr_i == OFF_SEED_HI |-> ##2 scrambler_seed_o[14:7] == $past(wr_data_i, 2);
   endproperty
   property p_pat;
      wr_en_i && addr_i == OFF_PATTERN |-> ##2 pattern_sequence_select_o == $past(wr_pat, 2);
   endproperty
   a_lx: assert property (p_lx) else $error("lane not crossed");
   a_ls: assert property (p_ls) else $error("lane not straight");
   a_cx: assert property (p_cx) else $error("samples not crossed");
   a_cs: assert property (p_cs) else $error("samples not straight");
   a_rsv: assert property (p_rsv) else $error("unused exchange bits not zero");
   a_lnk: assert property (p_lnk) else $error("link identifier read differs");
   a_shi: assert property (p_shi) else $error("seed high byte wrong");
   a_pat: assert property (p_pat) else $error("pattern select wrong");
   c_both: cover property (sw_wr && wr_pat == 2'h3);
   c_lnk: cover property (rd_en_i && addr_i == OFF_LINK_ID);
   c_p31: cover property (wr_en_i && addr_i == OFF_PATTERN && wr_pat == 2'h3);
endmodule // slcr_top_checker
bind slcr_top slcr_top_checker #(.SAMPLE_W(SAMPLE_W), .LANE_W(LANE_W)) u_chk (.clock_i,
   .reset_n_i, .addr_i, .wr_en_i, .wr_data_i, .rd_en_i, .rd_data_o, .rd_valid_o,
   .conv0_sample_i, .conv1_sample_i, .ser_in0_o, .ser_out0_i, .ser_out1_i, .lane0_data_o,
   .scrambler_seed_o, .pattern_sequence_select_o, .link_identifier_o);
`default_nettype wire

// ### tb/tb_slcr_top.sv
// bench for the configuration registers
`timescale 1ns/10ps
`default_nettype none
module tb_slcr_top;
   import slcr_pkg::*;
   localparam logic [11:0] RA [17] = '{12'h806, 12'h808, 12'h809, 12'h80a, 12'h80b, 12'h820,
      12'h821, 12'h822, 12'h823, 12'h824, 12'h825, 12'h826, 12'h827, 12'h828, 12'h829, 12'h82c,
      12'h82d};
   localparam logic [7:0] RM [17] = '{8'h03, 8'h07, 8'h7f, 8'hff, 8'h03, 8'h00, 8'h0f, 8'h81,
      8'h07, 8'h1f, 8'h01, 8'h4f, 8'h1f, 8'h01, 8'h83, 8'h1f, 8'h1f};
   localparam logic [7:0] RR [17] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h5a, 8'h03, 8'h00,
      8'h01, 8'h08, 8'h00, 8'h0b, 8'h0f, 8'h01, 8'h00, 8'h1b, 8'h1c};
   logic clock_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic wr_en_i = 1'b0;
   logic rd_en_i = 1'b0;
   logic [11:0] addr_i = 12'h000;
   logic [7:0] wr_data_i;
   logic [11:0] conv0_sample_i;
   logic [11:0] conv1_sample_i;
   logic [7:0] rd_data_o, lane0_checksum_o, lane1_checksum_o, rv;
   logic [11:0] ser_in0_o, ser_in1_o;
   logic [9:0] ser_out0_i, ser_out1_i, lane0_data_o, lane1_data_o;
   logic [1:0] pattern_sequence_select_o;
   logic rd_valid_o;
   logic [7:0] m [17];
   logic [31:0] seed = 32'h9792;
   logic [31:0] sseed = 32'h9792;
   int n_errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   slcr_top DUT (.clock_i, .reset_n_i, .addr_i, .wr_en_i, .wr_data_i, .rd_en_i, .rd_data_o,
      .rd_valid_o, .cfg_strap_i(4'h5), .conv0_sample_i, .conv1_sample_i, .ser_in0_o,
      .ser_in1_o, .ser_out0_i, .ser_out1_i, .lane0_data_o, .lane1_data_o, .swing_select_o(),
      .scrambler_seed_o(), .pattern_sequence_select_o, .link_identifier_o(),
      .bank_identifier_o(), .scramble_enable_o(), .lanes_o(), .octets_o(), .frames_o(),
      .converters_o(), .control_bits_o(), .resolution_o(), .total_bits_per_sample_o(),
      .samples_o(), .high_density_flag_o(), .control_words_per_frame_o(),
      .lane0_identifier_o(), .lane1_identifier_o(), .lane0_checksum_o, .lane1_checksum_o);
   slcr_ser_model u_ser (.clock_i, .reset_n_i, .ser_out0_o(ser_out0_i), .ser_out1_o(ser_out1_i));
   always #5 clock_i = ~clock_i;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
   endfunction
   task automatic complete_run();
      $display("checks %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // hang guard
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         complete_run();
      end
   end
   always @(posedge clock_i) begin
      #1;
      sseed = lfsr(sseed);
      {conv0_sample_i, conv1_sample_i} = sseed[23:0];
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clock_i);
      #1;
      wr_en_i = 1'b1;
      addr_i = a;
      wr_data_i = d;
      @(posedge clock_i);
      #1;
      wr_en_i = 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [7:0] d);
      @(posedge clock_i);
      #1;
      rd_en_i = 1'b1;
      addr_i = a;
      @(posedge clock_i);
      #1;
      rd_en_i = 1'b0;
      d = rd_data_o;
   endtask
   function automatic logic [7:0] csum(input logic [4:0] id);
      return m[5] + m[6][3:0] + id + m[7][7] + m[7][0] + m[8][2:0] + m[9][4:0] + m[10][0]
         + m[11][6] + m[11][3:0] + m[12][4:0] + m[13][0] + m[14][7] + m[14][1:0];
   endfunction
   task automatic data_check(input logic [1:0] sw);
      logic [9:0] p0, p1;
      logic [11:0] c0, c1;
      @(negedge clock_i);
      {p0, p1, c0, c1} = {ser_out0_i, ser_out1_i, conv0_sample_i, conv1_sample_i};
      @(posedge clock_i);
      #2;
      check(lane0_data_o, sw[1] ? p1 : p0);
      check(lane1_data_o, sw[1] ? p0 : p1);
      check(ser_in0_o, sw[0] ? c1 : c0);
      check(ser_in1_o, sw[0] ? c0 : c1);
   endtask
   initial begin
      repeat (12) @(posedge clock_i);
      #1 reset_n_i = 1'b1;
      repeat (6) @(posedge clock_i);
      for (int i = 0; i < 17; i++) begin
         m[i] = RR[i];
         rd(RA[i], rv);
         check(rv, RR[i]);
      end
      rd(12'h807, rv);
      check(rv, 8'h00);
      $display("done reset values");
      repeat (4) for (int i = 0; i < 17; i++) begin
         seed = lfsr(seed);
         wr(RA[i], seed[7:0]);
         m[i] = (m[i] & ~RM[i]) | (seed[7:0] & RM[i]);
      end
      for (int i = 0; i < 17; i++) begin
         rd(RA[i], rv);
         check(rv, m[i]);
      end
      wr(OFF_LANE0_CHK, 8'h00);
      rd(OFF_LANE0_CHK, rv);
      check(rv, csum(m[15][4:0]));
      rd(OFF_LANE1_CHK, rv);
      check(rv, csum(m[16][4:0]));
      check(lane0_checksum_o, csum(m[15][4:0]));
      check(lane1_checksum_o, csum(m[16][4:0]));
      $display("done access");
      for (int c = 0; c < 4; c++) begin
         wr(OFF_PATTERN, 8'(c));
         repeat (2) @(posedge clock_i);
         #1;
         check(pattern_sequence_select_o, 16'(c));
         wr(OFF_SWAP, {6'h3f, 2'(c)});
         data_check(2'(c));
         rd(OFF_SWAP, rv);
         check(rv, 16'(c));
      end
      wr(OFF_QUICK_CFG, 8'h01);
      rd(OFF_OCTETS, rv);
      check(rv, 8'h03);
      $display("done exchange");
      complete_run();
   end
endmodule // tb_slcr_top
`default_nettype wire
